/* File: design/sps_serial_port.sv */
// serial port core: frame format, parity, 16x oversampling with noise
// check, extended baud dividers, shared interrupt and low power gating.
// assumes a classic wishbone master and an asynchronous rxd line.
//
// Summary of operation
// - parity enable adds parity on transmit and checks it on receive.
// - word length alone chooses 8 or 9 payload bits.
// - parity select clear gives even ones over low data bits plus parity.
// - parity select set gives odd ones over low data bits plus parity.
// - with parity on, the top payload bit is sent as parity.
// - bad received parity sets parity error flag, interrupts when enabled.
// - address mark wake uses the top data bit, never the parity bit.
// - each bit sampled sixteen times; majority of samples 8, 9, 10.
// - disagreeing centre samples still give majority but set noise flag.
// - oversampling counter restarts on every detected start bit.
// - line sampled once per sampling tick, aligned only by start bit.
// - wait mode leaves serial work running; enabled events wake device.
// - halt freezes transfers and all register contents.
// - all serial events except noise merge onto one interrupt line.
// - an event interrupts only when enabled and cpu mask clear.
// - six flagged events each with its own enable bit.
// - every event except noise may end wait mode, none may end halt.
// - receive extension divider divides further by 1..255, zero bypasses.
// - transmit extension divider divides further by 1..255, zero bypasses.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module sps_serial_port #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ADDR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // serial line
   input wire logic rxd_in,
   output logic txd_out,
   // processor side
   input wire logic cpu_irq_mask_in,
   input wire logic wait_mode_in,
   input wire logic halt_mode_in,
   output logic irq_out,
   output logic wake_out
);

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
      $error("sps_serial_port: ADDR_W must be 5 to 8");
   end

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [2:0] sync;
      logic line;
      logic [5:0] ctrl;
      logic [5:0] ien;
      logic [6:0] flg;
      logic [7:0] fst_div;
      logic [7:0] tx_div;
      logic [7:0] rx_div;
      logic [7:0] rx_ext;
      logic [7:0] tx_ext;
      logic [7:0] fst_cnt;
      logic [7:0] tx_cnt;
      logic [7:0] rx_cnt;
      logic [7:0] tx_ecnt;
      logic [7:0] rx_ecnt;
      logic [8:0] tx_buf;
      sps_pkg::sps_tx_state_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_sub;
      logic txd;
      sps_pkg::sps_rx_state_t rx_st;
      logic [3:0] rx_sub;
      logic [3:0] rx_bits;
      logic [8:0] rx_sh;
      logic [1:0] smp;
      logic [8:0] rx_data;
      logic idle_arm;
      logic [7:0] idle_cnt;
      logic irq;
      logic wake;
   } sps_state_t;

   sps_state_t st_q;
   sps_state_t st_d;
   logic fst_tick, tx_tick, rx_tick;
   logic tx_load, rx_eval, rx_done, rx_maj, rx_noisy, rx_bad_par;
   logic [8:0] rx_word;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // divider end: a value of zero behaves like one
   function automatic logic div_end(input logic [7:0] cnt, input logic [7:0] div);
      div_end = (div == 8'h00) || (cnt >= div - 8'h01);
   endfunction

   // parity over the low 7 or 8 data bits, inverted for odd parity
   function automatic logic par_of(input logic [8:0] d, input logic wlen, input logic odd);
      logic [7:0] low;
      low = wlen ? d[7:0] : {1'b0, d[6:0]};
      par_of = (^low) ^ odd;
   endfunction

   // byte lane merge under wishbone select
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
      wmerge = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            wmerge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      sps_state_t n;
      logic [31:0] ctrl_w, baud_w;
      logic [3:0] nb, sub_n;
      logic [8:0] pay;
      logic nl, fall, msb, wl, par_on, po;
      n = st_q;
      ctrl_w = {18'h0_0000, st_q.ien, 2'b00, st_q.ctrl};
      baud_w = {8'h00, st_q.rx_div, st_q.tx_div, st_q.fst_div};
      tx_load = 1'b0;
      rx_eval = 1'b0;
      rx_done = 1'b0;
      rx_maj = 1'b0;
      rx_noisy = 1'b0;
      rx_bad_par = 1'b0;
      rx_word = 9'h000;
      pay = 9'h000;
      msb = 1'b0;
      sub_n = 4'h0;

      // bus slave: one wait state, ack drops after one cycle
      n.ack = wb_cyc_in & wb_stb_in & ~st_q.ack;
      if (n.ack) begin
         n.rdat = 32'h0000_0000; // unmapped reads as zero
         unique case (wb_adr_in)
            ADDR_W'(sps_pkg::OFS_CTRL): n.rdat = ctrl_w;
            ADDR_W'(sps_pkg::OFS_STAT): n.rdat = {25'h000_0000, st_q.flg};
            ADDR_W'(sps_pkg::OFS_DATA): n.rdat = {23'h00_0000, st_q.rx_data};
            ADDR_W'(sps_pkg::OFS_BAUD): n.rdat = baud_w;
            ADDR_W'(sps_pkg::OFS_RX_EXT): n.rdat = {24'h00_0000, st_q.rx_ext};
            ADDR_W'(sps_pkg::OFS_TX_EXT): n.rdat = {24'h00_0000, st_q.tx_ext};
            default: n.rdat = 32'h0000_0000;
         endcase
         if (wb_we_in) begin
            ctrl_w = wmerge(ctrl_w, wb_dat_in, wb_sel_in);
            baud_w = wmerge(baud_w, wb_dat_in, wb_sel_in);
            unique case (wb_adr_in)
               ADDR_W'(sps_pkg::OFS_CTRL): begin
                  n.ctrl = ctrl_w[5:0];
                  n.ien = ctrl_w[sps_pkg::CTRL_IEN_LO +: 6];
               end
               ADDR_W'(sps_pkg::OFS_STAT): begin
                  if (wb_sel_in[0]) begin
                     n.flg = st_q.flg & ~wb_dat_in[6:0]; // write one to clear
                  end
               end
               ADDR_W'(sps_pkg::OFS_DATA): begin
                  if (wb_sel_in[0]) begin
                     n.tx_buf[7:0] = wb_dat_in[7:0];
                  end
                  if (wb_sel_in[1]) begin
                     n.tx_buf[8] = wb_dat_in[8];
                  end
                  n.flg[sps_pkg::FLG_TX_EMPTY] = 1'b0;
                  n.flg[sps_pkg::FLG_TX_CMPL] = 1'b0;
               end
               ADDR_W'(sps_pkg::OFS_BAUD): begin
                  n.fst_div = baud_w[7:0];
                  n.tx_div = baud_w[sps_pkg::BAUD_TX_LO +: 8];
                  n.rx_div = baud_w[sps_pkg::BAUD_RX_LO +: 8];
               end
               ADDR_W'(sps_pkg::OFS_RX_EXT): begin
                  if (wb_sel_in[0]) begin
                     n.rx_ext = wb_dat_in[7:0];
                  end
               end
               ADDR_W'(sps_pkg::OFS_TX_EXT): begin
                  if (wb_sel_in[0]) begin
                     n.tx_ext = wb_dat_in[7:0];
                  end
               end
               default: n.rdat = 32'h0000_0000;
            endcase
         end else if (wb_adr_in == ADDR_W'(sps_pkg::OFS_DATA)) begin
            n.flg[sps_pkg::FLG_RX_FULL] = 1'b0; // reading data frees the buffer
         end
      end
      wl = n.ctrl[sps_pkg::CTRL_WLEN];
      par_on = n.ctrl[sps_pkg::CTRL_PAR_EN];
      po = n.ctrl[sps_pkg::CTRL_PAR_SEL];
      nb = wl ? 4'd9 : 4'd8;

      // baud chain: common first divider, per direction second and extension
      fst_tick = div_end(st_q.fst_cnt, st_q.fst_div);
      n.fst_cnt = fst_tick ? 8'h00 : st_q.fst_cnt + 8'h01;
      tx_tick = fst_tick & div_end(st_q.tx_cnt, st_q.tx_div);
      rx_tick = fst_tick & div_end(st_q.rx_cnt, st_q.rx_div);
      if (fst_tick) begin
         n.tx_cnt = div_end(st_q.tx_cnt, st_q.tx_div) ? 8'h00 : st_q.tx_cnt + 8'h01;
         n.rx_cnt = div_end(st_q.rx_cnt, st_q.rx_div) ? 8'h00 : st_q.rx_cnt + 8'h01;
      end
      if (st_q.tx_ext == 8'h00) begin
         n.tx_ecnt = 8'h00;
      end else if (tx_tick) begin
         n.tx_ecnt = div_end(st_q.tx_ecnt, st_q.tx_ext) ? 8'h00 : st_q.tx_ecnt + 8'h01;
      end
      tx_tick = tx_tick & div_end(st_q.tx_ecnt, st_q.tx_ext);
      if (st_q.rx_ext == 8'h00) begin
         n.rx_ecnt = 8'h00;
      end else if (rx_tick) begin
         n.rx_ecnt = div_end(st_q.rx_ecnt, st_q.rx_ext) ? 8'h00 : st_q.rx_ecnt + 8'h01;
      end
      rx_tick = rx_tick & div_end(st_q.rx_ecnt, st_q.rx_ext);

      // transmitter
      unique case (st_q.tx_st)
         sps_pkg::SPS_TX_IDLE: begin
            if (n.ctrl[sps_pkg::CTRL_TX_EN] && !n.flg[sps_pkg::FLG_TX_EMPTY]) begin
               tx_load = 1'b1;
               pay = wl ? n.tx_buf : {1'b1, n.tx_buf[7:0]};
               if (par_on) begin
                  pay[nb-4'd1] = par_of(n.tx_buf, wl, po);
               end
               n.tx_sh = {1'b1, pay, 1'b0};
               n.tx_bits = nb + 4'd2;
               n.tx_sub = 4'h0;
               n.flg[sps_pkg::FLG_TX_EMPTY] = 1'b1;
               n.tx_st = sps_pkg::SPS_TX_SEND;
            end
         end
         sps_pkg::SPS_TX_SEND: begin
            if (tx_tick) begin
               n.tx_sub = st_q.tx_sub + 4'h1;
               if (st_q.tx_sub == 4'hF) begin
                  n.tx_sh = {1'b1, st_q.tx_sh[10:1]}; // lsb first
                  n.tx_bits = st_q.tx_bits - 4'd1;
                  if (st_q.tx_bits == 4'd1) begin
                     n.tx_st = sps_pkg::SPS_TX_IDLE;
                     if (n.flg[sps_pkg::FLG_TX_EMPTY]) begin
                        n.flg[sps_pkg::FLG_TX_CMPL] = 1'b1;
                     end
                  end
               end
            end
         end
         default: n.tx_st = sps_pkg::SPS_TX_IDLE;
      endcase
      n.txd = (n.tx_st == sps_pkg::SPS_TX_SEND) ? n.tx_sh[0] : 1'b1;

      // line synchroniser: a change counts once stages two and three agree
      n.sync = {st_q.sync[1:0], rxd_in};
      nl = (st_q.sync[1] == st_q.sync[2]) ? st_q.sync[2] : st_q.line;
      n.line = nl;
      fall = st_q.line & ~nl;

      // receiver
      unique case (st_q.rx_st)
         sps_pkg::SPS_RX_IDLE: begin
            if (n.ctrl[sps_pkg::CTRL_RX_EN] && fall) begin
               n.rx_st = sps_pkg::SPS_RX_RECV;
               n.rx_sub = 4'h0;
               n.rx_bits = 4'd0;
               n.idle_cnt = 8'h00;
            end else if (rx_tick && st_q.idle_arm) begin
               n.idle_cnt = nl ? st_q.idle_cnt + 8'h01 : 8'h00;
               if (nl && st_q.idle_cnt == {nb + 4'd2, 4'h0} - 8'h01) begin
                  n.flg[sps_pkg::FLG_IDLE] = 1'b1;
                  n.idle_arm = 1'b0;
               end
            end
         end
         sps_pkg::SPS_RX_RECV: begin
            if (rx_tick) begin
               sub_n = st_q.rx_sub + 4'h1;
               n.rx_sub = sub_n;
               // one capture per sampling tick, no other alignment
               if (sub_n == sps_pkg::SMP_FIRST) begin
                  n.smp[0] = nl;
               end
               if (sub_n == sps_pkg::SMP_SECOND) begin
                  n.smp[1] = nl;
               end
               if (sub_n == sps_pkg::SMP_THIRD) begin
                  rx_eval = 1'b1;
                  rx_maj = (st_q.smp[0] & st_q.smp[1]) | (st_q.smp[0] & nl)
                     | (st_q.smp[1] & nl);
                  rx_noisy = !(st_q.smp[0] == st_q.smp[1] && st_q.smp[1] == nl);
                  if (rx_noisy) begin
                     n.flg[sps_pkg::FLG_NOISE] = 1'b1;
                  end
                  n.rx_bits = st_q.rx_bits + 4'd1;
                  if (st_q.rx_bits == 4'd0 && rx_maj) begin
                     n.rx_st = sps_pkg::SPS_RX_IDLE; // false start
                  end else if (st_q.rx_bits != 4'd0 && st_q.rx_bits <= nb) begin
                     n.rx_sh = {rx_maj, st_q.rx_sh[8:1]};
                  end else if (st_q.rx_bits > nb) begin
                     rx_done = 1'b1;
                  end
               end
            end
         end
         default: n.rx_st = sps_pkg::SPS_RX_IDLE;
      endcase
      if (rx_done) begin
         n.rx_st = sps_pkg::SPS_RX_IDLE;
         n.idle_arm = 1'b1;
         rx_word = wl ? st_q.rx_sh : {1'b0, st_q.rx_sh[8:1]};
         rx_bad_par = par_on & ((^rx_word) ^ po);
         if (rx_bad_par) begin
            n.flg[sps_pkg::FLG_PERR] = 1'b1;
         end
         // address mark: top data bit below the parity bit when parity is on
         msb = par_on ? rx_word[nb-4'd2] : rx_word[nb-4'd1];
         if (n.ctrl[sps_pkg::CTRL_WAKE] && msb) begin
            n.ctrl[sps_pkg::CTRL_WAKE] = 1'b0;
         end
         if (!n.ctrl[sps_pkg::CTRL_WAKE]) begin
            if (n.flg[sps_pkg::FLG_RX_FULL]) begin
               n.flg[sps_pkg::FLG_OVERRUN] = 1'b1;
            end else begin
               n.rx_data = rx_word;
               n.flg[sps_pkg::FLG_RX_FULL] = 1'b1;
            end
         end
      end

      // one shared request line, gated by the cpu mask
      n.irq = (|(n.flg[5:0] & n.ien)) & ~cpu_irq_mask_in;

      // halt freezes everything but the wake output, including the bus answer
      if (halt_mode_in) begin
         n = st_q;
      end
      // wait mode changes nothing; enabled events wake, never out of halt
      n.wake = ~halt_mode_in & wait_mode_in & (|(n.flg[5:0] & n.ien));

      if (sys_rst_in) begin
         n = '0;
         n.sync = 3'b111;
         n.line = 1'b1;
         n.flg = sps_pkg::FLG_RESET;
         n.fst_div = sps_pkg::DIV_RESET;
         n.tx_div = sps_pkg::DIV_RESET;
         n.rx_div = sps_pkg::DIV_RESET;
         n.rx_ext = sps_pkg::EXT_RESET;
         n.tx_ext = sps_pkg::EXT_RESET;
         n.txd = 1'b1;
         n.tx_st = sps_pkg::SPS_TX_IDLE;
         n.rx_st = sps_pkg::SPS_RX_IDLE;
      end
      st_d = n;
   end

   // state register
   always_ff @(posedge sys_clk_in) begin
      st_q <= st_d;
   end

   // outputs straight from flops
   assign wb_dat_out = st_q.rdat;
   assign wb_ack_out = st_q.ack;
   assign txd_out = st_q.txd;
   assign irq_out = st_q.irq;
   assign wake_out = st_q.wake;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   a_halt_holds_line: assert property (halt_mode_in |=> $stable(txd_out))
      else $error("txd moved during halt");
   a_halt_no_wake: assert property (halt_mode_in |=> !wake_out)
      else $error("wake raised during halt");
   a_mask_blocks_irq: assert property (cpu_irq_mask_in && !halt_mode_in |=> !irq_out)
      else $error("irq raised while cpu mask set");
   a_parity_sets_flag: assert property (rx_done && rx_bad_par && !halt_mode_in
      |=> st_q.flg[sps_pkg::FLG_PERR])
      else $error("parity error not flagged");
   a_no_parity_check: assert property (!st_d.ctrl[sps_pkg::CTRL_PAR_EN] && !halt_mode_in
      && rx_done |-> !rx_bad_par)
      else $error("parity checked while disabled");
   a_noise_sets_flag: assert property (rx_eval && rx_noisy && !halt_mode_in
      |=> st_q.flg[sps_pkg::FLG_NOISE])
      else $error("noise not flagged");
   a_start_resync: assert property (st_q.rx_st == sps_pkg::SPS_RX_IDLE
      && st_d.rx_st == sps_pkg::SPS_RX_RECV |=> st_q.rx_sub == 4'h0)
      else $error("sample counter not restarted at start bit");
   a_rx_ext_bypass: assert property (st_q.rx_ext == 8'h00 |=> st_q.rx_ecnt == 8'h00)
      else $error("rx extension divider ran while bypassed");
   a_tx_ext_bypass: assert property (st_q.tx_ext == 8'h00 |=> st_q.tx_ecnt == 8'h00)
      else $error("tx extension divider ran while bypassed");
   a_even_parity: assert property (tx_load && !halt_mode_in && st_d.ctrl[0] && !st_d.ctrl[1]
      && !st_d.ctrl[2] |=> ^st_q.tx_sh[8:1] == 1'b0)
      else $error("even parity wrong on transmit");
   a_odd_parity: assert property (tx_load && !halt_mode_in && st_d.ctrl[0] && st_d.ctrl[1]
      && st_d.ctrl[2] |=> ^st_q.tx_sh[9:1] == 1'b1)
      else $error("odd parity wrong on transmit");
   a_start_bit_low: assert property (tx_load && !halt_mode_in |=> !txd_out)
      else $error("start bit not low");

   c_frame_received: cover property (rx_done && !rx_bad_par);
   c_parity_error: cover property (rx_done && rx_bad_par);
   c_noise_seen: cover property (rx_eval && rx_noisy);
   c_wake_from_wait: cover property (wait_mode_in ##1 wake_out);

endmodule // sps_serial_port

/* File: design/sps_pkg.sv */
// package for the serial port parity and sampling block: register map,
// field positions, reset values, state encodings and sampling constants.
// assumes a 32-bit classic wishbone register bus and one system clock.
package sps_pkg;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00; // serial_control_one
   localparam logic [7:0] OFS_STAT = 8'h04; // serial_status
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_BAUD = 8'h0C;
   localparam logic [7:0] OFS_RX_EXT = 8'h10; // rx_ext_baud_divider
   localparam logic [7:0] OFS_TX_EXT = 8'h14; // tx_ext_baud_divider

   // ------------------------------------------------------------------
   // control and baud fields
   // ------------------------------------------------------------------
   localparam int CTRL_PAR_EN = 0;
   localparam int CTRL_PAR_SEL = 1;
   localparam int CTRL_WLEN = 2;
   localparam int CTRL_TX_EN = 3;
   localparam int CTRL_RX_EN = 4;
   localparam int CTRL_WAKE = 5;
   localparam int CTRL_IEN_LO = 8;
   localparam int BAUD_TX_LO = 8;
   localparam int BAUD_RX_LO = 16;

   // ------------------------------------------------------------------
   // status flags: 0 tx empty, 1 tx complete, 2 rx full, 3 overrun,
   // 4 idle line, 5 parity error, 6 noise
   // ------------------------------------------------------------------
   localparam int FLG_TX_EMPTY = 0;
   localparam int FLG_TX_CMPL = 1;
   localparam int FLG_RX_FULL = 2;
   localparam int FLG_OVERRUN = 3;
   localparam int FLG_IDLE = 4;
   localparam int FLG_PERR = 5;
   localparam int FLG_NOISE = 6;
   localparam logic [6:0] FLG_RESET = 7'h03;
   localparam logic [7:0] DIV_RESET = 8'h01;
   localparam logic [7:0] EXT_RESET = 8'h00;

   // ------------------------------------------------------------------
   // sampling
   // ------------------------------------------------------------------
   localparam logic [3:0] SMP_FIRST = 4'h8;
   localparam logic [3:0] SMP_SECOND = 4'h9;
   localparam logic [3:0] SMP_THIRD = 4'hA;
   localparam int SMP_PER_BIT_LOG2 = 4;

   typedef enum logic [1:0] {SPS_TX_IDLE = 2'b01, SPS_TX_SEND = 2'b10} sps_tx_state_t;
   typedef enum logic [1:0] {SPS_RX_IDLE = 2'b01, SPS_RX_RECV = 2'b10} sps_rx_state_t;

endpackage

/* File: dv/sps_far_end.sv */
// far end model: remote serial transmitter and receiver, 16 clocks per bit
// times div_in. assumes the design idles its transmit line high.
`timescale 1ns/1ps

module sps_far_end (
   // clock and bit length divider
   input wire logic clk_in,
   input wire logic [7:0] div_in,
   // serial lines
   input wire logic line_in,
   output logic line_out,
   // ten bits seen after the last start bit, and a frame count
   output logic [9:0] got_out,
   output logic [7:0] frames_out
);
   // line is pulled high while no frame is sent
   initial begin
      line_out = 1'b1;
      got_out = 10'h000;
      frames_out = 8'h00;
   end

   // exact bit timing, so the drift limit is met with margin; an optional
   // glitch of div_in clocks near the centre of bit 0 disturbs one centre
   // sample; a one clock glitch would be swallowed by the input filter
   task automatic send(input logic [9:0] v, input int n, input bit glitch);
      logic b;
      for (int i = -1; i <= n; i++) begin
         b = (i < 0) ? 1'b0 : ((i == n) ? 1'b1 : v[i]);
         line_out <= b;
         repeat (9 * div_in) @(posedge clk_in);
         line_out <= (glitch && i == 0) ? ~b : b;
         repeat (div_in) @(posedge clk_in);
         line_out <= b;
         repeat (6 * div_in) @(posedge clk_in);
      end
   endtask

   // receiver samples mid bit and re-arms on the next falling edge
   initial forever begin
      @(negedge line_in);
      repeat (8 * div_in) @(posedge clk_in);
      for (int i = 0; i < 10; i++) begin
         repeat (16 * div_in) @(posedge clk_in);
         got_out[i] <= line_in;
      end
      frames_out <= frames_out + 8'h01;
   end
endmodule // sps_far_end

/* File: dv/testbench.sv */
// testbench: wishbone register tasks, a table of transmit frames, then
// receive, interrupt and low power cases. assumes sps_far_end on the line.
`timescale 1ns/1ps

module testbench;
   typedef struct packed {
      logic [31:0] ctl;
      logic [31:0] dat;
      logic [9:0] frm;
   } sps_row_t;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cyc, stb, we, mask, wait_m, halt_m, rxd, txd, irq, wake, ack;
   logic [7:0] adr, div, frames, n;
   logic [31:0] wdat, rdat, dout;
   logic [9:0] got;
   int err_total = 0;
   int samples_checked = 0;
   // expected line bits: ten bits after start, lsb first, then stop / idle
   sps_row_t rows [6] = '{
      '{32'h0000_0008, 32'h0000_0035, 10'h335},
      '{32'h0000_0009, 32'h0000_00B5, 10'h335},
      '{32'h0000_000B, 32'h0000_0035, 10'h3B5},
      '{32'h0000_000C, 32'h0000_01AA, 10'h3AA},
      '{32'h0000_000D, 32'h0000_0135, 10'h235},
      '{32'h0000_000F, 32'h0000_0003, 10'h303}};

   always #2 sys_clk_in = ~sys_clk_in;

   sps_serial_port u_sps_serial_port (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
      .wb_dat_in(wdat), .wb_dat_out(dout), .wb_ack_out(ack), .rxd_in(rxd), .txd_out(txd),
      .cpu_irq_mask_in(mask), .wait_mode_in(wait_m), .halt_mode_in(halt_m),
      .irq_out(irq), .wake_out(wake));
   sps_far_end u_sps_far_end (.clk_in(sys_clk_in), .div_in(div), .line_in(txd),
      .line_out(rxd), .got_out(got), .frames_out(frames));

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d compares %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // request held until ack is sampled high; read data taken at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge sys_clk_in);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) err_total++;
      rdat = dout;
      {cyc, stb} <= 2'b00;
      @(posedge sys_clk_in);
   endtask
   task automatic tx_frame(input logic [31:0] d);
      int k;
      n = frames;
      wb(1'b1, sps_pkg::OFS_DATA, d);
      for (k = 0; k < 4000 && frames == n; k++) @(posedge sys_clk_in);
      if (frames == n) err_total++;
   endtask
   task automatic wait_rx();
      for (int k = 0; k < 300; k++) begin
         wb(1'b0, sps_pkg::OFS_STAT, '0);
         if (rdat[sps_pkg::FLG_RX_FULL] === 1'b1) break;
      end
      if (rdat[sps_pkg::FLG_RX_FULL] !== 1'b1) err_total++;
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      {cyc, stb, we, adr, wdat, mask, wait_m, halt_m} = '0;
      div = 8'h01;
      repeat (6) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge sys_clk_in);
      wb(1'b0, sps_pkg::OFS_STAT, '0);
      chk(rdat, 32'h0000_0003);
      wb(1'b0, sps_pkg::OFS_RX_EXT, '0);
      chk(rdat, 32'h0000_0000);
      wb(1'b0, 8'h40, '0);
      chk(rdat, 32'h0000_0000);
      foreach (rows[i]) begin
         wb(1'b1, sps_pkg::OFS_CTRL, rows[i].ctl);
         tx_frame(rows[i].dat);
         chk({22'h0, got}, {22'h0, rows[i].frm});
      end
      // extension dividers at 2 double the bit length in both directions
      div <= 8'h02;
      wb(1'b1, sps_pkg::OFS_TX_EXT, 32'h0000_0002);
      wb(1'b1, sps_pkg::OFS_RX_EXT, 32'h0000_0002);
      wb(1'b1, sps_pkg::OFS_CTRL, 32'h0000_0018);
      tx_frame(32'h0000_005A);
      chk({22'h0, got}, 32'h0000_035A);
      u_sps_far_end.send(10'h03C, 8, 1'b0);
      wait_rx();
      wb(1'b0, sps_pkg::OFS_DATA, '0);
      chk(rdat, 32'h0000_003C);
      div <= 8'h01;
      wb(1'b1, sps_pkg::OFS_TX_EXT, '0);
      wb(1'b1, sps_pkg::OFS_RX_EXT, '0);
      // odd parity expected, even sent: error flag, interrupt, wake
      wb(1'b1, sps_pkg::OFS_CTRL, 32'h0000_201B);
      u_sps_far_end.send(10'h035, 8, 1'b0);
      wait_rx();
      chk(rdat & 32'h0000_006C, 32'h0000_0024);
      chk(irq, 1'b1);
      mask <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      chk(irq, 1'b0);
      {mask, wait_m} <= 2'b01;
      repeat (3) @(posedge sys_clk_in);
      chk(wake, 1'b1);
      halt_m <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      chk(wake, 1'b0);
      chk(txd, 1'b1);
      {halt_m, wait_m} <= 2'b00;
      wb(1'b0, sps_pkg::OFS_DATA, '0);
      chk(rdat, 32'h0000_0035);
      wb(1'b1, sps_pkg::OFS_STAT, 32'h0000_0078);
      // one disturbed centre sample: majority value kept, noise flagged;
      // two clocks per tick so a filtered glitch covers exactly one sample
      div <= 8'h02;
      wb(1'b1, sps_pkg::OFS_RX_EXT, 32'h0000_0002);
      wb(1'b1, sps_pkg::OFS_CTRL, 32'h0000_0010);
      u_sps_far_end.send(10'h0A5, 8, 1'b1);
      wait_rx();
      chk(rdat & 32'h0000_0044, 32'h0000_0044);
      wb(1'b0, sps_pkg::OFS_DATA, '0);
      chk(rdat, 32'h0000_00A5);
      // address mark wake: word with top bit clear dropped, marked word kept
      wb(1'b1, sps_pkg::OFS_CTRL, 32'h0000_0030);
      u_sps_far_end.send(10'h005, 8, 1'b0);
      u_sps_far_end.send(10'h085, 8, 1'b0);
      wait_rx();
      wb(1'b0, sps_pkg::OFS_DATA, '0);
      chk(rdat, 32'h0000_0085);
      finish_test();
   end

   // watchdog: the sequence needs well under 20000 cycles
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule // testbench
